// ===== core/evc_top.v
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`include "evc_consts.vh"

// Function
// - Edge select picks rising or falling edges
// - Gating 0..4: none, high, low, edge-start
// - Gating 10..12: neighbour terminal count or gates
// - Shape select: toggle or pulse at terminal count
// - Pulse shape: invert chooses pulse level
// - Toggle shape: invert chooses first toggle direction
// - All selects reset to zero
// - Stored config applied when counter is started
// - Timebase 0 counts lower counter's terminal count
// - Timebases 1..5 are internal divided clocks
// - Timebases 6..10 pick group source pins
// - Timebases 11..15 pick group gate pins
// - Chaining stays inside each group of five
// - Stop mode halts at wrap, flags overflow
// - Continue mode wraps freely, no overflow
// - Start clears count, counts up, applies settings
// - Count readback never disturbs counting

module evc_top #(
    parameter TB4_HALF = `EVC_HALF(`EVC_TB4_NS),
    parameter TB5_HALF = `EVC_HALF(`EVC_TB5_NS)
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Counter pins
    input wire [9:0] source_in,
    input wire [9:0] gate_in,
    output wire [9:0] counter_out
);

// ==========================================================
// Declarations
// Fast timebases are fixed; the slow two are parameters so a bench can shorten them
localparam [16:0] TB1_HALF = 17'd10;
localparam [16:0] TB2_HALF = 17'd100;
localparam [16:0] TB3_HALF = 17'd1000;

// Stored settings and start strobes, one entry per counter
reg [6:0] cfg_ff [0:9];
reg [4:0] ctl_ff [0:9];
reg [9:0] start_ff;
reg [16:0] div_ff [0:4];
reg [4:0] tb_lvl_ff;
// Next bus answer, worked out combinationally
reg [31:0] nxt_prdata;
reg nxt_pslverr;
// Synchronised pins, gate in the upper half
wire [19:0] pin_sync;
wire [9:0] src_s;
wire [9:0] gate_s;
// Live count state sits in each channel; the top only routes it
wire [159:0] count_flat;
wire [9:0] ovf_w;
wire [9:0] run_w;
wire [9:0] tc_w;
wire [39:0] tb_flat;
wire [39:0] gsel_flat;
// Bus decode
wire [3:0] slot;
wire [1:0] word;
wire slot_ok;
wire acc;
wire commit;
// Loop indices, one per process
integer k;
integer j;

// ==========================================================
// Helper functions

// Gating codes the counters understand
function gate_valid;
    input [3:0] code;
    begin
        case (code)
            `EVC_GATE_NONE, `EVC_GATE_HIGH, `EVC_GATE_LOW,
            `EVC_GATE_RISE, `EVC_GATE_FALL, `EVC_GATE_TC_LOWER,
            `EVC_GATE_GT_HIGHER, `EVC_GATE_GT_LOWER,
            `EVC_GATE_SPECIAL: gate_valid = 1'b1;
            default: gate_valid = 1'b0;
        endcase
    end
endfunction

// Position of a counter inside its group
function [2:0] grp_pos;
    input integer idx;
    integer rel;
    begin
        rel = (idx < `EVC_GRP_SIZE) ? idx : idx - `EVC_GRP_SIZE;
        grp_pos = rel[2:0];
    end
endfunction

// Count source by timebase code, never leaving the counter's group
// A missing lower neighbour reads as a steady low, so nothing counts there
function cnt_pick;
    input [3:0] tb;
    input integer idx;
    input [9:0] src;
    input [9:0] gat;
    input [9:0] tcv;
    input [4:0] tbw;
    integer base;
    begin
        base = (idx < `EVC_GRP_SIZE) ? 0 : `EVC_GRP_SIZE;
        case (tb)
            4'h0: cnt_pick = (grp_pos(idx) == 3'd0) ? 1'b0 : tcv[idx - 1];
            4'h1: cnt_pick = tbw[0];
            4'h2: cnt_pick = tbw[1];
            4'h3: cnt_pick = tbw[2];
            4'h4: cnt_pick = tbw[3];
            4'h5: cnt_pick = tbw[4];
            4'h6: cnt_pick = src[base];
            4'h7: cnt_pick = src[base + 1];
            4'h8: cnt_pick = src[base + 2];
            4'h9: cnt_pick = src[base + 3];
            4'ha: cnt_pick = src[base + 4];
            4'hb: cnt_pick = gat[base];
            4'hc: cnt_pick = gat[base + 1];
            4'hd: cnt_pick = gat[base + 2];
            4'he: cnt_pick = gat[base + 3];
            4'hf: cnt_pick = gat[base + 4];
            default: cnt_pick = 1'b0;
        endcase
    end
endfunction

// Gate source by gating code, neighbours taken inside the group only
function gate_pick;
    input [3:0] gm;
    input integer idx;
    input [9:0] gat;
    input [9:0] tcv;
    begin
        case (gm)
            `EVC_GATE_TC_LOWER:
                gate_pick = (grp_pos(idx) == 3'd0) ? 1'b0 : tcv[idx - 1];
            `EVC_GATE_GT_HIGHER:
                gate_pick = (grp_pos(idx) == 3'd4) ? 1'b0 : gat[idx + 1];
            `EVC_GATE_GT_LOWER:
                gate_pick = (grp_pos(idx) == 3'd0) ? 1'b0 : gat[idx - 1];
            default: gate_pick = gat[idx];
        endcase
    end
endfunction

// Half period of each internal timebase in clock cycles
function [16:0] tb_half;
    input integer n;
    begin
        case (n)
            0: tb_half = TB1_HALF;
            1: tb_half = TB2_HALF;
            2: tb_half = TB3_HALF;
            3: tb_half = TB4_HALF[16:0];
            default: tb_half = TB5_HALF[16:0];
        endcase
    end
endfunction

// ==========================================================
// Pin synchronisers

// Pins pass two flops before any counter logic reads them
evc_sync u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .pin_in({gate_in, source_in}),
    .pin_sync_ff(pin_sync)
);

assign src_s = pin_sync[9:0];
assign gate_s = pin_sync[19:10];

// ==========================================================
// Internal timebases

// Square waves, so every counter sees one rising edge per period
// Dividers are shared and free-running, so the first tick after a start may come early
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        for (k = 0; k < 5; k = k + 1) begin
            div_ff[k] <= 17'h0_0000;
        end
        tb_lvl_ff <= 5'h00;
    end else begin
        for (k = 0; k < 5; k = k + 1) begin
            if (div_ff[k] >= tb_half(k) - 17'h0_0001) begin
                div_ff[k] <= 17'h0_0000;
                tb_lvl_ff[k] <= ~tb_lvl_ff[k];
            end else begin
                div_ff[k] <= div_ff[k] + 17'h0_0001;
            end
        end
    end
end

// ==========================================================
// APB decode

// One 16-byte slot per counter; slots 10..15 and the fourth word are holes
assign slot = paddr[7:4];
assign word = paddr[3:2];
assign slot_ok = (slot < 4'd10) & (word != 2'h3);
assign acc = psel & penable;
assign commit = acc & pready;

// Read data and error for the access in progress
always @* begin
    nxt_prdata = 32'h0000_0000;
    nxt_pslverr = 1'b0;
    if (!slot_ok) begin
        nxt_pslverr = 1'b1;
    end else begin
        case (word)
            `EVC_REG_CONFIG: begin
                nxt_prdata = {25'h000_0000, cfg_ff[slot]};
                // Unknown gating code is turned away with an error
                if (pwrite && !gate_valid(pwdata[`EVC_CFG_GATE_HI:`EVC_CFG_GATE_LO])) begin
                    nxt_pslverr = 1'b1;
                end
            end
            `EVC_REG_CONTROL: begin
                // Start bit is never stored, so it reads back as zero
                nxt_prdata = {27'h000_0000, ctl_ff[slot]};
            end
            `EVC_REG_COUNT: begin
                // Plain snapshot of live state; nothing is paused or cleared
                nxt_prdata = {14'h0000, run_w[slot], ovf_w[slot],
                              count_flat[slot * 16 +: 16]};
            end
            default: begin
                nxt_pslverr = 1'b1;
            end
        endcase
    end
end

// One wait state: pready rises in the second access cycle
// Read data moves only on reads, so it holds until the next read
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        prdata <= 32'h0000_0000;
        pready <= 1'b0;
        pslverr <= 1'b0;
    end else begin
        pready <= acc & ~pready;
        if (acc & ~pready) begin
            pslverr <= nxt_pslverr;
            if (!pwrite) begin
                prdata <= nxt_prdata;
            end
        end else begin
            pslverr <= 1'b0;
        end
    end
end

// ==========================================================
// Configuration and control store

// Writes land only at the completing edge, and only if not refused
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        for (j = 0; j < `EVC_NUM_CTR; j = j + 1) begin
            cfg_ff[j] <= `EVC_CFG_RST;
            ctl_ff[j] <= `EVC_CTL_RST;
        end
        start_ff <= 10'h000;
    end else begin
        start_ff <= 10'h000;
        // Refused and unmapped writes leave the store untouched
        if (commit && pwrite && !pslverr) begin
            case (word)
                `EVC_REG_CONFIG: begin
                    cfg_ff[slot] <= pwdata[6:0];
                end
                `EVC_REG_CONTROL: begin
                    ctl_ff[slot] <= pwdata[4:0];
                    // Start is a one-cycle strobe and is never stored
                    start_ff[slot] <= pwdata[`EVC_CTL_START];
                end
                `EVC_REG_COUNT: begin
                    // Count word is read-only; a write is dropped without an error
                end
                default: begin
                end
            endcase
        end
    end
end

// ==========================================================
// Counter channels

genvar i;
generate
    for (i = 0; i < `EVC_NUM_CTR; i = i + 1) begin : g_chan
        wire cnt_lvl;
        wire gate_lvl;

        // Sources follow the latched selects, so a running count is stable
        assign cnt_lvl = cnt_pick(tb_flat[i * 4 +: 4], i, src_s, gate_s, tc_w, tb_lvl_ff);
        assign gate_lvl = gate_pick(gsel_flat[i * 4 +: 4], i, gate_s, tc_w);

        // Each counter latches its own settings at start
        evc_chan u_chan (
            .clk(pclk),
            .rst_n(presetn),
            .start(start_ff[i]),
            .cfg(cfg_ff[i]),
            .ctl(ctl_ff[i]),
            .cnt_lvl(cnt_lvl),
            .gate_lvl(gate_lvl),
            .count_ff(count_flat[i * 16 +: 16]),
            .ovf_ff(ovf_w[i]),
            .run_ff(run_w[i]),
            .tc_ff(tc_w[i]),
            .out_ff(counter_out[i]),
            .act_tb_ff(tb_flat[i * 4 +: 4]),
            .act_gate_ff(gsel_flat[i * 4 +: 4])
        );
    end
endgenerate

endmodule

// ===== core/evc_consts.vh
`ifndef EVC_CONSTS_VH
`define EVC_CONSTS_VH

// ==========================================================
// Geometry
`define EVC_NUM_CTR 10
`define EVC_GRP_SIZE 5
`define EVC_PIN_W 20

// ==========================================================
// Register offsets inside one counter slot (word index)
`define EVC_SLOT_BYTES 16
`define EVC_REG_CONFIG 2'h0
`define EVC_REG_CONTROL 2'h1
`define EVC_REG_COUNT 2'h2

// ==========================================================
// Config word fields
`define EVC_CFG_EDGE 0
`define EVC_CFG_GATE_LO 1
`define EVC_CFG_GATE_HI 4
`define EVC_CFG_SHAPE 5
`define EVC_CFG_INV 6
`define EVC_CFG_RST 7'h00

// Control word fields
`define EVC_CTL_TB_LO 0
`define EVC_CTL_TB_HI 3
`define EVC_CTL_CONT 4
`define EVC_CTL_START 5
`define EVC_CTL_RST 5'h00

// Count word fields
`define EVC_CNT_OVF 16
`define EVC_CNT_RUN 17

// ==========================================================
// Gating select codes
`define EVC_GATE_NONE 4'h0
`define EVC_GATE_HIGH 4'h1
`define EVC_GATE_LOW 4'h2
`define EVC_GATE_RISE 4'h3
`define EVC_GATE_FALL 4'h4
`define EVC_GATE_TC_LOWER 4'ha
`define EVC_GATE_GT_HIGHER 4'hb
`define EVC_GATE_GT_LOWER 4'hc
`define EVC_GATE_SPECIAL 4'hd

// ==========================================================
// Timing: clock and internal timebase periods in ns
`define EVC_CLK_NS 50
`define EVC_TB1_NS 1000
`define EVC_TB2_NS 10000
`define EVC_TB3_NS 100000
`define EVC_TB4_NS 1000000
`define EVC_TB5_NS 10000000
`define EVC_HALF(p) (((p) / `EVC_CLK_NS) / 2)

`endif

// ===== core/evc_sync.v
`timescale 1ns/10ps

// ==========================================================
// Two-stage synchroniser for the source and gate pins
module evc_sync (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Asynchronous pins
    input wire [19:0] pin_in,
    // Synchronised levels
    output reg [19:0] pin_sync_ff
);

reg [19:0] meta_ff;

// First stage feeds only the second stage
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        meta_ff <= 20'h0_0000;
        pin_sync_ff <= 20'h0_0000;
    end else begin
        meta_ff <= pin_in;
        pin_sync_ff <= meta_ff;
    end
end

endmodule

// ===== core/evc_chan.v
`timescale 1ns/10ps
`include "evc_consts.vh"

// ==========================================================
// One 16-bit up-counter with gating and output shaping
module evc_chan (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Start strobe and stored settings
    input wire start,
    input wire [6:0] cfg,
    input wire [4:0] ctl,
    // Selected count and gate levels
    input wire cnt_lvl,
    input wire gate_lvl,
    // State
    output reg [15:0] count_ff,
    output reg ovf_ff,
    output reg run_ff,
    output reg tc_ff,
    output reg out_ff,
    output reg [3:0] act_tb_ff,
    output reg [3:0] act_gate_ff
);

reg act_edge_ff;
reg act_shape_ff;
reg act_inv_ff;
reg act_cont_ff;
reg cnt_prev_ff;
reg gate_prev_ff;
reg armed_ff;
reg tog_ff;
reg gate_ok;
wire cnt_edge;
wire step;
wire wrap;
wire nxt_tc;
wire nxt_tog;

// Edge of the chosen count input
assign cnt_edge = act_edge_ff ? (cnt_prev_ff & ~cnt_lvl) : (~cnt_prev_ff & cnt_lvl);

// Gate interpretation; special mode counts ungated for now
always @* begin
    gate_ok = 1'b1;
    case (act_gate_ff)
        `EVC_GATE_NONE: gate_ok = 1'b1;
        `EVC_GATE_HIGH: gate_ok = gate_lvl;
        `EVC_GATE_LOW: gate_ok = ~gate_lvl;
        `EVC_GATE_RISE: gate_ok = armed_ff;
        `EVC_GATE_FALL: gate_ok = armed_ff;
        `EVC_GATE_TC_LOWER: gate_ok = gate_lvl;
        `EVC_GATE_GT_HIGHER: gate_ok = gate_lvl;
        `EVC_GATE_GT_LOWER: gate_ok = gate_lvl;
        `EVC_GATE_SPECIAL: gate_ok = 1'b1;
        default: gate_ok = 1'b1;
    endcase
end

assign step = run_ff & gate_ok & cnt_edge;
assign wrap = step & (count_ff == 16'hffff);
assign nxt_tc = wrap & ~start;
assign nxt_tog = start ? 1'b0 : (tog_ff ^ wrap);

// Settings are latched at start, so later config writes wait for the next start
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        act_edge_ff <= 1'b0;
        act_gate_ff <= 4'h0;
        act_shape_ff <= 1'b0;
        act_inv_ff <= 1'b0;
        act_tb_ff <= 4'h0;
        act_cont_ff <= 1'b0;
    end else if (start) begin
        act_edge_ff <= cfg[`EVC_CFG_EDGE];
        act_gate_ff <= cfg[`EVC_CFG_GATE_HI:`EVC_CFG_GATE_LO];
        act_shape_ff <= cfg[`EVC_CFG_SHAPE];
        act_inv_ff <= cfg[`EVC_CFG_INV];
        act_tb_ff <= ctl[`EVC_CTL_TB_HI:`EVC_CTL_TB_LO];
        act_cont_ff <= ctl[`EVC_CTL_CONT];
    end
end

// Count, rollover and overflow; a wrap beside a start still flags
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        count_ff <= 16'h0000;
        run_ff <= 1'b0;
        ovf_ff <= 1'b0;
        armed_ff <= 1'b0;
        cnt_prev_ff <= 1'b0;
        gate_prev_ff <= 1'b0;
        tc_ff <= 1'b0;
        tog_ff <= 1'b0;
        out_ff <= 1'b0;
    end else begin
        cnt_prev_ff <= cnt_lvl;
        gate_prev_ff <= gate_lvl;
        tc_ff <= nxt_tc;
        tog_ff <= nxt_tog;
        ovf_ff <= (wrap & ~act_cont_ff) | (ovf_ff & ~start);
        if (start) begin
            count_ff <= 16'h0000;
            run_ff <= 1'b1;
            armed_ff <= 1'b0;
        end else begin
            if (step) begin
                count_ff <= count_ff + 16'h0001;
            end
            if (wrap & ~act_cont_ff) begin
                run_ff <= 1'b0;
            end
            if ((act_gate_ff == `EVC_GATE_RISE) & ~gate_prev_ff & gate_lvl) begin
                armed_ff <= 1'b1;
            end
            if ((act_gate_ff == `EVC_GATE_FALL) & gate_prev_ff & ~gate_lvl) begin
                armed_ff <= 1'b1;
            end
        end
        // Toggle starts low before the invert, so invert picks the first direction
        if (act_shape_ff) begin
            out_ff <= nxt_tc ^ act_inv_ff;
        end else begin
            out_ff <= nxt_tog ^ act_inv_ff;
        end
    end
end

endmodule

// ===== bench/evc_pins.sv
`timescale 1ns/10ps

// ==========================================================
// Far-side pins: source and gate levels seen by the counters
module evc_pins (
    // Clock
    input wire pclk,
    // Pins into the block
    output reg [9:0] source_in,
    output reg [9:0] gate_in
);
    // Pins idle low until a scenario moves them
    initial begin
        source_in = 10'h000;
        gate_in = 10'h000;
    end

    // Set one source (g=0) or gate (g=1) pin to a level
    task set_pin(input g, input integer i, input v);
        begin
            @(posedge pclk);
            if (g) gate_in[i] <= v;
            else source_in[i] <= v;
        end
    endtask

    // Pulses four cycles wide so the two-stage synchroniser never misses one
    task pulse(input g, input integer i, input integer n);
        integer k;
        begin
            for (k = 0; k < n; k = k + 1) begin
                set_pin(g, i, 1'b1);
                repeat (3) @(posedge pclk);
                set_pin(g, i, 1'b0);
                repeat (3) @(posedge pclk);
            end
        end
    endtask
endmodule

// ===== bench/evc_chk_sva.sv
`timescale 1ns/10ps

// ==========================================================
// Port-level checks of the counter block
module evc_chk (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // Counter pins
    input wire [9:0] counter_out
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Decoded view of the finishing transfer
    wire done_w = psel && penable && pready;
    wire mapped_w = (paddr[7:4] < 4'ha) && (paddr[3:2] != 2'h3);
    wire [3:0] gsel_w = pwdata[4:1];
    wire bad_gate_w = !((gsel_w <= 4'h4) || (gsel_w >= 4'ha && gsel_w <= 4'hd));
    wire cfg_wr_w = pwrite && mapped_w && (paddr[3:2] == 2'h0);

    wait_state_a: assert property (psel && !penable ##1 psel && penable |-> !pready ##1 pready)
        else $error("pready not after one wait state");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    ready_cause_a: assert property (pready |-> psel && penable)
        else $error("pready outside an access");
    err_valid_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    unmapped_err_a: assert property (done_w && !mapped_w |-> pslverr && (pwrite || prdata == 0))
        else $error("unmapped access not refused");
    bad_gate_a: assert property (done_w && cfg_wr_w && bad_gate_w |-> pslverr)
        else $error("invalid gating accepted");
    good_code_a: assert property (done_w && mapped_w && !(cfg_wr_w && bad_gate_w) |-> !pslverr)
        else $error("valid access refused");
    count_word_a: assert property (done_w && !pwrite && mapped_w && paddr[3:2] == 2'h2
        |-> prdata[31:18] == 0)
        else $error("count word upper bits set");
    reset_out_a: assert property ($rose(presetn) |-> counter_out == 10'h000 [*2])
        else $error("outputs not idle after reset");

    // Main scenarios reached
    cover property (done_w && pwrite && paddr[3:2] == 2'h1 && pwdata[5]);
    cover property (done_w && pslverr);
    cover property (counter_out != 10'h000);
endmodule

// ===== bench/testbench.sv
`timescale 1ns/10ps
`include "evc_consts.vh"

// ==========================================================
// Self-checking bench for the counter block
module testbench;
    reg pclk = 1'b0;
    reg presetn = 1'b0;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg [7:0] paddr = 8'h00;
    reg [31:0] pwdata = 32'h0000_0000;
    wire [31:0] prdata;
    wire pready;
    wire pslverr;
    wire [9:0] source_in;
    wire [9:0] gate_in;
    wire [9:0] counter_out;
    integer errors = 0;
    integer checked = 0;

    // 20 MHz bus clock
    always #25 pclk = ~pclk;

    // Short slow timebases keep the run small
    evc_top #(.TB4_HALF(40), .TB5_HALF(80)) evc_top_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .source_in(source_in),
        .gate_in(gate_in), .counter_out(counter_out)
    );
    evc_pins evc_pins_inst (.pclk(pclk), .source_in(source_in), .gate_in(gate_in));

    // ==========================================================
    // Helpers
    function [7:0] adr(input [3:0] c, input [1:0] w);
        adr = {c, w, 2'b00};
    endfunction

    task wrap_up;
        begin
            $display("checked %0d errors %0d", checked, errors);
            if (errors == 0 && checked > 0) $display("No errors found");
            else $display("Errors were found");
            $finish;
        end
    endtask

    task chk(input string name, input [31:0] exp, input [31:0] got);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
            end
        end
    endtask

    // One APB transfer; on a read d is the expected data, e the expected error
    task xfer(input w, input [7:0] a, input [31:0] d, input e);
        integer n;
        reg [31:0] r;
        reg s;
        begin
            @(posedge pclk);
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= w;
            paddr <= a;
            pwdata <= w ? d : 32'h0000_0000;
            @(posedge pclk);
            penable <= 1'b1;
            n = 0;
            @(posedge pclk);
            while (pready !== 1'b1 && n < 20) begin
                n = n + 1;
                @(posedge pclk);
            end
            if (pready !== 1'b1) begin
                errors = errors + 1;
                wrap_up;
            end else begin
                r = prdata;
                s = pslverr;
                psel <= 1'b0;
                penable <= 1'b0;
                chk("pslverr", {31'h0, e}, {31'h0, s});
                if (!w) chk("prdata", d, r);
            end
        end
    endtask

    // Synchroniser plus edge detect plus count update
    task settle;
        repeat (6) @(posedge pclk);
    endtask

    // ==========================================================
    // Scenarios
    task t_reset;
        integer i;
        begin
            for (i = 0; i < 10; i = i + 1) begin
                xfer(0, adr(i, `EVC_REG_CONFIG), 32'h0000_0000, 0);
                xfer(0, adr(i, `EVC_REG_CONTROL), 32'h0000_0000, 0);
            end
            chk("counter_out", 32'h0000_0000, {22'h0, counter_out});
            $display("test reset done");
        end
    endtask

    task t_codes;
        integer g;
        reg [3:0] good;
        reg bad;
        begin
            good = 4'h0;
            for (g = 0; g < 16; g = g + 1) begin
                bad = !(g <= 4 || (g >= 10 && g <= 13));
                xfer(1, adr(2, `EVC_REG_CONFIG), g << 1, bad);
                if (!bad) good = g;
                xfer(0, adr(2, `EVC_REG_CONFIG), {27'h0, good, 1'b0}, 0);
            end
            xfer(0, adr(12, `EVC_REG_CONFIG), 32'h0000_0000, 1);
            xfer(1, adr(3, 2'h3), 32'h0000_1234, 1);
            $display("test codes done");
        end
    endtask

    task t_edges;
        begin
            xfer(1, adr(0, `EVC_REG_CONFIG), 32'h0000_0000, 0);
            xfer(1, adr(0, `EVC_REG_CONTROL), 32'h0000_0026, 0);
            evc_pins_inst.pulse(0, 0, 3);
            settle;
            xfer(0, adr(0, `EVC_REG_COUNT), 32'h0002_0003, 0);
            xfer(0, adr(0, `EVC_REG_COUNT), 32'h0002_0003, 0);
            xfer(1, adr(0, `EVC_REG_CONFIG), 32'h0000_0001, 0);
            evc_pins_inst.set_pin(0, 0, 1'b1);
            settle;
            xfer(0, adr(0, `EVC_REG_COUNT), 32'h0002_0004, 0);
            xfer(1, adr(0, `EVC_REG_CONTROL), 32'h0000_0026, 0);
            xfer(0, adr(0, `EVC_REG_COUNT), 32'h0002_0000, 0);
            evc_pins_inst.set_pin(0, 0, 1'b0);
            settle;
            xfer(0, adr(0, `EVC_REG_COUNT), 32'h0002_0001, 0);
            $display("test edges done");
        end
    endtask

    task t_gate;
        begin
            xfer(1, adr(1, `EVC_REG_CONFIG), 32'h0000_0002, 0);
            xfer(1, adr(1, `EVC_REG_CONTROL), 32'h0000_0027, 0);
            evc_pins_inst.pulse(0, 1, 2);
            settle;
            xfer(0, adr(1, `EVC_REG_COUNT), 32'h0002_0000, 0);
            evc_pins_inst.set_pin(1, 1, 1'b1);
            evc_pins_inst.pulse(0, 1, 2);
            settle;
            xfer(0, adr(1, `EVC_REG_COUNT), 32'h0002_0002, 0);
            xfer(1, adr(1, `EVC_REG_CONFIG), 32'h0000_0004, 0);
            xfer(1, adr(1, `EVC_REG_CONTROL), 32'h0000_0027, 0);
            evc_pins_inst.pulse(0, 1, 2);
            settle;
            xfer(0, adr(1, `EVC_REG_COUNT), 32'h0002_0000, 0);
            xfer(1, adr(4, `EVC_REG_CONFIG), 32'h0000_0006, 0);
            xfer(1, adr(4, `EVC_REG_CONTROL), 32'h0000_002a, 0);
            evc_pins_inst.pulse(0, 4, 1);
            evc_pins_inst.pulse(1, 4, 1);
            evc_pins_inst.pulse(0, 4, 2);
            settle;
            xfer(0, adr(4, `EVC_REG_COUNT), 32'h0002_0002, 0);
            xfer(1, adr(2, `EVC_REG_CONFIG), 32'h0000_0016, 0);
            xfer(1, adr(2, `EVC_REG_CONTROL), 32'h0000_0028, 0);
            evc_pins_inst.pulse(0, 2, 1);
            evc_pins_inst.set_pin(1, 3, 1'b1);
            evc_pins_inst.pulse(0, 2, 2);
            settle;
            xfer(0, adr(2, `EVC_REG_COUNT), 32'h0002_0002, 0);
            $display("test gate done");
        end
    endtask

    task t_group;
        begin
            xfer(1, adr(6, `EVC_REG_CONTROL), 32'h0000_0026, 0);
            evc_pins_inst.pulse(0, 0, 1);
            evc_pins_inst.pulse(0, 5, 1);
            settle;
            xfer(0, adr(6, `EVC_REG_COUNT), 32'h0002_0001, 0);
            xfer(1, adr(6, `EVC_REG_CONTROL), 32'h0000_002c, 0);
            evc_pins_inst.pulse(1, 1, 1);
            evc_pins_inst.pulse(1, 6, 2);
            settle;
            xfer(0, adr(6, `EVC_REG_COUNT), 32'h0002_0002, 0);
            $display("test group done");
        end
    endtask

    task t_outs;
        begin
            xfer(1, adr(3, `EVC_REG_CONFIG), 32'h0000_0040, 0);
            xfer(1, adr(3, `EVC_REG_CONTROL), 32'h0000_0021, 0);
            settle;
            chk("out3", 32'h0000_0001, {31'h0, counter_out[3]});
            xfer(1, adr(3, `EVC_REG_CONFIG), 32'h0000_0020, 0);
            xfer(1, adr(3, `EVC_REG_CONTROL), 32'h0000_0021, 0);
            settle;
            chk("out3", 32'h0000_0000, {31'h0, counter_out[3]});
            $display("test outs done");
        end
    endtask

    // Main sequence
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_codes;
        t_edges;
        t_gate;
        t_group;
        t_outs;
        wrap_up;
    end
endmodule

bind evc_top evc_chk evc_chk_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .counter_out(counter_out)
);
